// ===== design/spsp_port.sv
// Port slot scheduler, link power control and PLL sequencing
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ps
// Operation
// - The port has 32 slots with a 32-bit issue vector where a set bit marks a pending slot.
// - Pending slots issue in ascending order from slot 0, regardless of the last slot issued.
// - Writing 1 to command bit 1 requests drive spin-up, set after PHY and DMA start.
// - Command bit 26 enables aggressive power transitions and bit 27 picks partial or slumber.
// - With aggressive transitions on, only the link goes low power once no command is left.
// - PLL go bit 0 written 0 unlocks the PLL and written 1 relocks it.
// - After that pulse, a reinit pulse on core misc bit 0 plus a new spin-up request restores communication with the drive.
module spsp_port
    import spsp_pkg::*;
#(
    parameter int SLOTS = SPSP_SLOTS,
    parameter int SW = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Command issue towards the link
    output logic cmd_valid_o,
    output logic [SW-1:0] cmd_slot_o,
    input wire logic cmd_ready_i,
    // Command completion from the drive
    input wire logic cmd_done_i,
    input wire logic [SW-1:0] cmd_done_slot_i,
    // Link state
    output logic link_active_o,
    output logic link_lowpwr_o,
    output logic link_slumber_o,
    output logic pll_locked_o
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [SLOTS-1:0] pend;
        logic [SLOTS-1:0] issd;
        logic [31:0] cmd;
        logic pll_go;
        logic reinit;
        logic stale;
        logic need_spin;
        spsp_link_type link;
        logic iss_v;
        logic [SW-1:0] iss_slot;
        logic ack;
        logic [31:0] dat;
    } spsp_state_type;

    spsp_state_type st_r;
    spsp_state_type st_nxt;

    logic cand_found;
    logic [SW-1:0] cand_idx;

    spsp_prio_enc #(
        .N(SLOTS),
        .W(SW)
    ) u_prio (
        .req_i(st_r.pend & ~st_r.issd),
        .found_o(cand_found),
        .idx_o(cand_idx)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic acc;
        logic wr;
        logic [31:0] wmask;
        logic [31:0] wval;
        logic [SLOTS-1:0] set_v;
        logic [SLOTS-1:0] clr_v;
        logic pll_ok;
        logic spin_wr;
        acc = 1'b0;
        wr = 1'b0;
        wmask = '0;
        wval = '0;
        set_v = '0;
        clr_v = '0;
        pll_ok = 1'b0;
        spin_wr = 1'b0;
        st_nxt = st_r;

        // One wait state: ack one cycle after the request
        acc = wb_cyc_i & wb_stb_i & ~st_r.ack;
        wr = acc & wb_we_i;
        st_nxt.ack = acc;
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wval = wb_dat_i & wmask;

        if (acc & ~wb_we_i) begin
            unique case (wb_adr_i)
                SPSP_OFS_SLOT_ISSUE: st_nxt.dat = 32'(st_r.pend);
                SPSP_OFS_PORT_CMD: st_nxt.dat = st_r.cmd;
                SPSP_OFS_PLL_CTRL: st_nxt.dat = {31'h0000_0000, st_r.pll_go};
                SPSP_OFS_CORE_MISC: st_nxt.dat = {31'h0000_0000, st_r.reinit};
                SPSP_OFS_STATUS: st_nxt.dat = {22'h00_0000, st_r.iss_slot, st_r.iss_v,
                    st_r.need_spin, st_r.stale, st_r.link};
                default: st_nxt.dat = 32'h0000_0000;
            endcase
        end

        // write ones to mark slots pending
        if (wr && wb_adr_i == SPSP_OFS_SLOT_ISSUE) begin
            set_v = wval[SLOTS-1:0];
        end
        // spin-up, DMA start; power mode bits
        if (wr && wb_adr_i == SPSP_OFS_PORT_CMD) begin
            st_nxt.cmd = (st_r.cmd & ~(wmask & SPSP_CMD_MASK)) | (wval & SPSP_CMD_MASK);
            spin_wr = wmask[SPSP_CMD_SPINUP] & wb_dat_i[SPSP_CMD_SPINUP];
        end
        // go bit, 0 unlocks, 1 relocks
        if (wr && wb_adr_i == SPSP_OFS_PLL_CTRL && wb_sel_i[0]) begin
            st_nxt.pll_go = wb_dat_i[SPSP_PLL_GO];
        end
        if (wr && wb_adr_i == SPSP_OFS_CORE_MISC && wb_sel_i[0]) begin
            st_nxt.reinit = wb_dat_i[SPSP_MISC_REINIT];
        end

        // unlock leaves the PLL stale until a reinit pulse
        // Set on the unlock edge so a pulse while unlocked really clears it
        if (st_r.reinit && !st_nxt.reinit) begin
            st_nxt.stale = 1'b0;
        end
        if (st_r.pll_go && !st_nxt.pll_go) begin
            st_nxt.stale = 1'b1;
        end

        // PLL disturbance forces a fresh spin-up request
        pll_ok = st_r.pll_go & ~st_r.reinit;
        if (!pll_ok) begin
            st_nxt.need_spin = 1'b1;
        end else if (spin_wr) begin
            st_nxt.need_spin = 1'b0;
        end

        // Issue stage; a held slot stays offered until taken
        if (st_r.iss_v && cmd_ready_i) begin
            st_nxt.iss_v = 1'b0;
        end
        // no issue unless the link is up
        if (!st_r.iss_v && cand_found && st_r.link == SPSP_LK_ACTIVE && pll_ok &&
            st_r.cmd[SPSP_CMD_DMA_START]) begin
            st_nxt.iss_v = 1'b1;
            st_nxt.iss_slot = cand_idx;
            st_nxt.issd[cand_idx] = 1'b1;
        end
        if (cmd_done_i) begin
            clr_v[cmd_done_slot_i] = 1'b1;
        end
        // a new pending write wins over a completion
        st_nxt.pend = (st_r.pend & ~clr_v) | set_v;
        st_nxt.issd = st_nxt.issd & ~clr_v;

        // Link power state
        unique case (st_r.link)
            SPSP_LK_OFF: begin
                // clean PLL plus spin-up brings the link back
                if (st_r.cmd[SPSP_CMD_SPINUP] && pll_ok && !st_r.need_spin) begin
                    st_nxt.link = st_r.stale ? SPSP_LK_LOCKUP : SPSP_LK_ACTIVE;
                end
            end
            SPSP_LK_ACTIVE: begin
                // idle link enters low power, controller stays awake
                if (st_r.cmd[SPSP_CMD_ALPM_EN] && st_r.pend == '0 && !st_r.iss_v) begin
                    st_nxt.link = SPSP_LK_LOWPWR;
                end
            end
            SPSP_LK_LOWPWR: begin
                if (st_r.pend != '0 || !st_r.cmd[SPSP_CMD_ALPM_EN]) begin
                    st_nxt.link = SPSP_LK_ACTIVE;
                end
            end
            SPSP_LK_LOCKUP: begin
                // Skipped reinit pulse: only a later pulse frees the port
                if (!st_r.stale) begin
                    st_nxt.link = SPSP_LK_OFF;
                end
            end
        endcase
        if (st_r.link != SPSP_LK_LOCKUP && (!st_r.cmd[SPSP_CMD_SPINUP] || !pll_ok)) begin
            st_nxt.link = SPSP_LK_OFF;
        end
        // Cancelled offer must not leave its slot marked as issued
        if (st_nxt.link != SPSP_LK_ACTIVE && !st_r.iss_v) begin
            st_nxt.iss_v = 1'b0;
            if (cand_found) begin
                st_nxt.issd[cand_idx] = 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.cmd <= SPSP_CMD_RST;
            st_r.pll_go <= SPSP_PLL_GO_RST;
            st_r.need_spin <= 1'b1;
            st_r.link <= SPSP_LK_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;
    assign cmd_valid_o = st_r.iss_v;
    assign cmd_slot_o = st_r.iss_slot;
    assign link_active_o = (st_r.link == SPSP_LK_ACTIVE);
    // bit 27 selects slumber over partial
    assign link_lowpwr_o = (st_r.link == SPSP_LK_LOWPWR);
    assign link_slumber_o = (st_r.link == SPSP_LK_LOWPWR) & st_r.cmd[SPSP_CMD_ALPM_SLUMBER];
    assign pll_locked_o = st_r.pll_go & ~st_r.reinit;
endmodule

// ===== inc/spsp_pkg.sv
// Constants and types for the port slot issue and PLL sequencing block
package spsp_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] SPSP_OFS_SLOT_ISSUE = 8'h00;
    localparam logic [7:0] SPSP_OFS_PORT_CMD = 8'h04;
    localparam logic [7:0] SPSP_OFS_PLL_CTRL = 8'h08;
    localparam logic [7:0] SPSP_OFS_CORE_MISC = 8'h0c;
    localparam logic [7:0] SPSP_OFS_STATUS = 8'h10;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int SPSP_CMD_DMA_START = 0;
    localparam int SPSP_CMD_SPINUP = 1;
    localparam int SPSP_CMD_ALPM_EN = 26;
    localparam int SPSP_CMD_ALPM_SLUMBER = 27;
    localparam int SPSP_PLL_GO = 0;
    localparam int SPSP_MISC_REINIT = 0;

    // Writable bits of the port command register
    localparam logic [31:0] SPSP_CMD_MASK = 32'h0c00_0003;

    // ---------------------------------------------------------------
    // Reset values and slot count
    // ---------------------------------------------------------------
    localparam logic [31:0] SPSP_CMD_RST = 32'h0000_0000;
    localparam logic SPSP_PLL_GO_RST = 1'b1;
    localparam int SPSP_SLOTS = 32;

    // ---------------------------------------------------------------
    // Link states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SPSP_LK_OFF = 2'b00,
        SPSP_LK_ACTIVE = 2'b01,
        SPSP_LK_LOWPWR = 2'b11,
        SPSP_LK_LOCKUP = 2'b10
    } spsp_link_type;

endpackage

// ===== design/spsp_prio_enc.sv
// Fixed-priority finder: lowest set request index wins
`timescale 1ns/1ps
module spsp_prio_enc #(
    parameter int N = 32,
    parameter int W = 5
) (
    // Requests
    input wire logic [N-1:0] req_i,
    // Result
    output logic found_o,
    output logic [W-1:0] idx_o
);
    always_comb begin
        found_o = 1'b0;
        idx_o = '0;
        // Scan down so the lowest index is written last
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                found_o = 1'b1;
                idx_o = W'(i);
            end
        end
    end
endmodule

// ===== dv/spsp_port_props.sv
// Checker on the pins of the port block
`timescale 1ns/1ps
module spsp_port_props #(
    parameter int SW = 5
) (
    // Watched pins
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cmd_valid_o,
    input wire logic [SW-1:0] cmd_slot_o,
    input wire logic cmd_ready_i,
    input wire logic link_active_o,
    input wire logic link_lowpwr_o,
    input wire logic pll_locked_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_unlock;
        s_req ##0 (wb_we_i && wb_adr_i == 8'h08 && wb_sel_i[0] && !wb_dat_i[0]);
    endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_bad_read: assert property (s_req ##0 (!wb_we_i && wb_adr_i > 8'h10) |=> wb_dat_o == 32'h0)
        else $error("unmapped read");
    a_slot_hold: assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_slot_o))
        else $error("offer dropped");
    a_issue_gap: assert property (cmd_valid_o && cmd_ready_i |=> !cmd_valid_o) else $error("no gap");
    a_issue_gate: assert property ($rose(cmd_valid_o) |-> $past(pll_locked_o) && $past(link_active_o))
        else $error("issue while down");
    a_unlock_drop: assert property (s_unlock |-> ##2 !pll_locked_o)
        else $error("pll still locked");
    a_unlock_off: assert property (!pll_locked_o |=> !link_active_o)
        else $error("link up while unlocked");
    a_lowpwr_idle: assert property (link_lowpwr_o |-> !cmd_valid_o)
        else $error("issue in low power");
endmodule
bind spsp_port spsp_port_props #(.SW(SW)) spsp_port_props_i (.*);

// ===== dv/spsp_drive_model.sv
// Drive-side model: takes offered slots, reports completions later
`timescale 1ns/1ps
module spsp_drive_model (
    // Clock, reset and pacing
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    // Issue and completion
    input wire logic cmd_valid_i,
    input wire logic [4:0] cmd_slot_i,
    output logic cmd_ready_o,
    output logic cmd_done_o,
    output logic [4:0] cmd_done_slot_o
);
    logic [4:0] q[$];
    logic [2:0] t = 3'h0;
    initial {cmd_ready_o, cmd_done_o, cmd_done_slot_o} = 7'h0;
    always @(posedge clk_i) begin
        // Idle slot lines toggle so a stale value is never trusted
        cmd_done_o <= 1'b0;
        cmd_done_slot_o <= ~cmd_done_slot_o;
        t <= t + 3'h1;
        cmd_ready_o <= !slow_i || t[1];
        if (rst_i) begin
            q.delete();
        end else begin
            if (cmd_valid_i && cmd_ready_o) q.push_back(cmd_slot_i);
            if (q.size() > 0 && (!slow_i || t == 3'h0)) begin
                cmd_done_o <= 1'b1;
                cmd_done_slot_o <= q.pop_front();
            end
        end
    end
endmodule

// ===== dv/tb.sv
// Self-checking bench for the port slot scheduler and PLL sequencing
`timescale 1ns/1ps
module tb
    import spsp_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [3:0] sel_n = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, cmd_valid_o, cmd_ready_i, cmd_done_i, slow = 1'b0;
    logic link_active_o, link_lowpwr_o, link_slumber_o, pll_locked_o;
    logic [4:0] cmd_slot_o, cmd_done_slot_i;
    logic [4:0] obs[$];
    int n_fail = 0, checks = 0, cyc_n = 0, seed = 32'h8d8a5560;
    always #12.5 clk_i = ~clk_i;
    spsp_port #(.SLOTS(32), .SW(5)) spsp_port_i (.*);
    spsp_drive_model spsp_drive_model_i (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
        .cmd_valid_i(cmd_valid_o), .cmd_slot_i(cmd_slot_o), .cmd_ready_o(cmd_ready_i),
        .cmd_done_o(cmd_done_i), .cmd_done_slot_o(cmd_done_slot_i));
    always @(posedge clk_i) if (!rst_i && cmd_valid_o && cmd_ready_i) obs.push_back(cmd_slot_o);
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic chk(input bit ok, input string m);
        checks++;
        if (!ok) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel_n;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    function automatic logic [4:0] nth_set(logic [31:0] v, int k);
        for (int i = 0; i < 32; i++) if (v[i] && k-- == 0) return 5'(i);
        return 5'h0;
    endfunction
    // DMA start first, spin-up after, as the start-up order asks
    task automatic bring_up(input logic up);
        wb(1'b1, SPSP_OFS_PORT_CMD, 32'h1);
        wb(1'b1, SPSP_OFS_PORT_CMD, 32'h3);
        for (int i = 0; i < 40 && link_active_o !== 1'b1; i++) @(posedge clk_i);
        chk(link_active_o === up, "link state after spin-up");
    endtask
    task automatic round(input logic [31:0] v, input logic slum);
        wb(1'b1, SPSP_OFS_PORT_CMD, {4'h0, slum, 1'b1, 26'h3});
        obs.delete();
        wb(1'b1, SPSP_OFS_SLOT_ISSUE, v);
        while (obs.size() < $countones(v)) @(posedge clk_i);
        for (int k = 0; k < $countones(v); k++) chk(obs[k] === nth_set(v, k), "order");
        do wb(1'b0, SPSP_OFS_SLOT_ISSUE, 32'h0); while (rd !== 32'h0);
        repeat (3) @(posedge clk_i);
        chk(link_lowpwr_o === 1'b1 && link_slumber_o === slum, "low power");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(pll_locked_o === SPSP_PLL_GO_RST && link_active_o === 1'b0, "reset pins");
        wb(1'b0, SPSP_OFS_PORT_CMD, 32'h0);
        chk(rd === SPSP_CMD_RST, "command reset value");
        // Top lane only: power mode bits land, spin-up and DMA stay clear
        sel_n = 4'h8;
        wb(1'b1, SPSP_OFS_PORT_CMD, 32'hffff_ffff);
        sel_n = 4'hf;
        wb(1'b0, SPSP_OFS_PORT_CMD, 32'h0);
        chk(rd === 32'h0c00_0000, "lane write");
        wb(1'b1, 8'h40, $random(seed));
        wb(1'b0, 8'h40, 32'h0);
        chk(rd === 32'h0, "unmapped read");
        bring_up(1'b1);
        // Slot 17 last, then a full vector: slot 0 must still lead
        round(32'h0002_0000, 1'b0);
        round(32'hffff_ffff, 1'b1);
        for (int r = 0; r < 3; r++) begin
            slow <= r[0];
            round($random(seed) | 32'h8000_0000, r[1]);
        end
        wb(1'b1, SPSP_OFS_PORT_CMD, 32'h2);
        wb(1'b1, SPSP_OFS_PORT_CMD, 32'h0);
        wb(1'b1, SPSP_OFS_PLL_CTRL, 32'h0);
        @(posedge clk_i);
        chk(pll_locked_o === 1'b0 && link_active_o === 1'b0, "unlock");
        wb(1'b1, SPSP_OFS_PLL_CTRL, 32'h1);
        bring_up(1'b0);
        wb(1'b0, SPSP_OFS_STATUS, 32'h0);
        chk(rd[1:0] === 2'b10, "lockup state");
        wb(1'b1, SPSP_OFS_PORT_CMD, 32'h0);
        wb(1'b1, SPSP_OFS_PLL_CTRL, 32'h0);
        wb(1'b1, SPSP_OFS_CORE_MISC, 32'h1);
        wb(1'b1, SPSP_OFS_CORE_MISC, 32'h0);
        wb(1'b1, SPSP_OFS_PLL_CTRL, 32'h1);
        bring_up(1'b1);
        round($random(seed) | 32'h1, 1'b0);
        end_of_test();
    end
endmodule
